// *** src/cbt_ctrl.sv ***
`timescale 1ns/10ps
`include "cbt_params.svh"

module cbt_ctrl #(
    parameter int CAL_TIME_NS = `CBT_CAL_TIME_NS
) (
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                termination_mode_reg_wr,
    input  cbt_pkg::cbt_strength_type cmd_term_strength_field,
    input  wire logic                termination_select_reg_wr,
    input  wire logic                cmd_line_term_disable,
    input  wire logic                clock_pair_term_enable,
    input  wire logic                chip_select_term_enable,
    input  wire logic                multirank_term_strap,
    input  wire logic                power_down,
    input  wire logic                self_refresh,
    input  wire logic                pu_cal_point,
    input  wire logic                cal_start,
    output cbt_pkg::cbt_lines_type   ca_term_on,
    output logic                     ck_term_on,
    output logic                     cs_term_on,
    output cbt_pkg::cbt_strength_type term_divisor,
    output logic                     cal_busy,
    output logic                     recal_needed,
    output logic                     forbidden_setting
);

    import cbt_pkg::*;

    // Least calibration time, rounded up to whole cycles
    localparam int CAL_CYCLES =
        (CAL_TIME_NS + `CBT_CLK_PERIOD_NS - 1) / `CBT_CLK_PERIOD_NS;
    localparam int CNT_W = $clog2(CAL_CYCLES + 1);
    localparam int AST_CAL_MAX = CAL_CYCLES + 1;

    typedef struct packed {
        cbt_cal_state_type cal_st;
        logic [CNT_W-1:0]  cal_cnt;
        cbt_strength_type  strength;
        logic              ca_dis;
        logic              ck_en;
        logic              cs_en;
        logic              cal_point;
        logic              recal;
        logic              forbid;
        cbt_lines_type     ca_on;
        logic              ck_on;
        logic              cs_on;
        cbt_strength_type  divisor;
    } cbt_ctrl_state_type;

    cbt_ctrl_state_type s_q;
    cbt_ctrl_state_type s_d;
    logic               strap_s;
    logic               str_valid;
    logic               ca_group_on;
    logic               cal_done;

    // Bond pad is asynchronous to the clock
    cbt_sync u_strap_sync (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (multirank_term_strap),
        .sync_out (strap_s)
    );

    // Enabled only for the listed codes; 000 and 111 fall out
    assign str_valid = (s_q.strength >= `CBT_STRENGTH_MIN) &&
                       (s_q.strength <= `CBT_STRENGTH_MAX);

    // Command lines need strap high and no line disable
    assign ca_group_on = str_valid && strap_s
                         && !s_q.ca_dis;

    assign cal_done = (s_q.cal_st == CBT_CAL) &&
                      (s_q.cal_cnt == '0);

    // Next state; power-down and self-refresh are not inputs to
    // the decode, so termination carries through those states
    always_comb begin
        s_d = s_q;

        // Strength taken at once, calibrated or not
        if (termination_mode_reg_wr) begin
            s_d.strength = cmd_term_strength_field;
        end
        if (termination_select_reg_wr) begin
            s_d.ca_dis = cmd_line_term_disable;
            s_d.ck_en  = clock_pair_term_enable;
            s_d.cs_en  = chip_select_term_enable;
        end

        // Termination decode from the held configuration
        s_d.ca_on = {`CBT_CA_LINES{ca_group_on}};
        if (!str_valid) begin
            s_d.ck_on = 1'b0;
            s_d.cs_on = 1'b0;
        end else if (strap_s) begin
            s_d.ck_on = 1'b1;
            s_d.cs_on = 1'b1;
        end else begin
            s_d.ck_on = s_q.ck_en;
            s_d.cs_on = s_q.cs_en;
        end
        s_d.divisor = str_valid ? s_q.strength
                                : `CBT_STRENGTH_OFF;

        // Flag strengths not usable at the high calibration point
        s_d.forbid = str_valid && s_q.cal_point &&
                     (s_q.strength >= `CBT_FORBID_MIN);

        // Calibration sequencer; a start while busy is ignored
        case (s_q.cal_st)
            CBT_IDLE: begin
                if (cal_start) begin
                    s_d.cal_st  = CBT_CAL;
                    s_d.cal_cnt = CNT_W'(CAL_CYCLES - 1);
                end
            end
            CBT_CAL: begin
                if (cal_done) begin
                    s_d.cal_st    = CBT_IDLE;
                    s_d.cal_point = pu_cal_point;
                end else begin
                    s_d.cal_cnt = s_q.cal_cnt - CNT_W'(1);
                end
            end
            default: begin
                s_d.cal_st  = CBT_IDLE;
                s_d.cal_cnt = '0;
            end
        endcase

        // Point change sets, completed calibration clears;
        // the clear wins when both meet in one cycle, as completion latches the current point
        if (cal_done) begin
            s_d.recal = 1'b0;
        end
        if (pu_cal_point != s_d.cal_point) begin
            s_d.recal = 1'b1;
        end

        // Synchronous reset: all termination off
        if (!nrst) begin
            s_d           = '0;
            s_d.cal_st    = CBT_IDLE;
            s_d.strength  = `CBT_STRENGTH_OFF;
            s_d.ca_dis    = `CBT_SEL_RESET;
            s_d.ck_en     = `CBT_SEL_RESET;
            s_d.cs_en     = `CBT_SEL_RESET;
            s_d.cal_point = `CBT_POINT_RESET;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    // Outputs straight from the state register
    assign ca_term_on        = s_q.ca_on;
    assign ck_term_on        = s_q.ck_on;
    assign cs_term_on        = s_q.cs_on;
    assign term_divisor      = s_q.divisor;
    assign cal_busy          = s_q.cal_st[1];     // One-hot busy bit
    assign recal_needed      = s_q.recal;
    assign forbidden_setting = s_q.forbid;

    // Checks next to the decode they guard

    AST_RESET_OFF: assert property (
        @(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> (ca_term_on == '0) && !ck_term_on && !cs_term_on
    ) else $error("termination on right after reset");

    AST_DISABLED_OFF: assert property (
        @(posedge clock) disable iff (!nrst)
        !str_valid |=> (ca_term_on == '0) && !ck_term_on && !cs_term_on
                       && (term_divisor == `CBT_STRENGTH_OFF)
    ) else $error("termination on with strength disabled");

    AST_LINES_TOGETHER: assert property (
        @(posedge clock) disable iff (!nrst)
        (ca_term_on == '0) ||
        ((ca_term_on == '1) && ck_term_on && cs_term_on)
    ) else $error("command lines terminated unevenly");

    AST_DIVISOR: assert property (
        @(posedge clock) disable iff (!nrst)
        str_valid |=> term_divisor == $past(s_q.strength)
    ) else $error("divisor does not follow strength");

    AST_STRAP_LOW_CA: assert property (
        @(posedge clock) disable iff (!nrst)
        !strap_s |=> ca_term_on == '0
    ) else $error("command lines terminated with strap low");

    AST_STRAP_LOW_SEL: assert property (
        @(posedge clock) disable iff (!nrst)
        (str_valid && !strap_s) |=>
            (ck_term_on == $past(s_q.ck_en)) &&
            (cs_term_on == $past(s_q.cs_en))
    ) else $error("clock or select ignores its enable");

    AST_STRAP_HIGH: assert property (
        @(posedge clock) disable iff (!nrst)
        (str_valid && strap_s) |=>
            ck_term_on && cs_term_on &&
            (ca_term_on == {`CBT_CA_LINES{!$past(s_q.ca_dis)}})
    ) else $error("strap high decode wrong");

    AST_POWER_DOWN: assert property (
        @(posedge clock) disable iff (!nrst)
        ((power_down || self_refresh) && str_valid && strap_s) ##1
        (power_down || self_refresh) |-> ck_term_on && cs_term_on
    ) else $error("termination dropped in power-down");

    AST_STRAP_KEPT: assert property (
        @(posedge clock) disable iff (!nrst)
        $stable(multirank_term_strap) ##1
        ($rose(power_down) && $stable(multirank_term_strap)) ##1
        $stable(multirank_term_strap) |-> $stable(strap_s)
    ) else $error("strap state moved on power-down");

    AST_STRENGTH_NOCAL: assert property (
        @(posedge clock) disable iff (!nrst)
        (termination_mode_reg_wr && !recal_needed &&
         (pu_cal_point == s_q.cal_point) && !cal_start) |=>
            (s_q.strength == $past(cmd_term_strength_field)) &&
            !recal_needed
    ) else $error("strength change demanded a calibration");

    AST_CAL_ENDS: assert property (
        @(posedge clock) disable iff (!nrst)
        $rose(cal_busy) |-> ##[1:AST_CAL_MAX] !cal_busy
    ) else $error("calibration never ends");

endmodule

// *** src/cbt_params.svh ***
// Function
// - Terminate clock pair, chip select, six lines
// - Strength codes 1..6 select reference over n
// - Reset and disabled strength turn everything off
// - Strap low never terminates command lines
// - Strap low: clock, select follow enables
// - Strap high: all on, command lines disableable
// - Termination stays on in power-down states
// - Power-down leaves strap state untouched
// - Strength change needs no new calibration
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH

// Command bus shape
`define CBT_CA_LINES      6
`define CBT_STRENGTH_W    3

// Strength codes
`define CBT_STRENGTH_OFF  3'h0
`define CBT_STRENGTH_MIN  3'h1
`define CBT_STRENGTH_MAX  3'h6
`define CBT_FORBID_MIN    3'h4

// Reset values of the select bits
`define CBT_SEL_RESET     1'h0
`define CBT_POINT_RESET   1'h0

// Timing
`define CBT_CLK_PERIOD_NS 25
`define CBT_CAL_TIME_NS   1000

`endif

// *** src/cbt_pkg.sv ***
`include "cbt_params.svh"

package cbt_pkg;

    // Strength field of the mode register
    typedef logic [`CBT_STRENGTH_W-1:0] cbt_strength_type;

    // Per-line termination vector
    typedef logic [`CBT_CA_LINES-1:0] cbt_lines_type;

    // Calibration sequencer, one-hot
    typedef enum logic [1:0] {
        CBT_IDLE = 2'h1,
        CBT_CAL  = 2'h2
    } cbt_cal_state_type;

endpackage

// *** src/cbt_sync.sv ***
`timescale 1ns/10ps

module cbt_sync (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic async_in,
    output logic      sync_out
);

    // Two stages; only the second is read
    typedef struct packed {
        logic meta;
        logic sync;
    } cbt_sync_state_type;

    cbt_sync_state_type s_q;
    cbt_sync_state_type s_d;

    // Shift the pad level in
    always_comb begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
        if (!nrst) begin
            s_d = '0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    assign sync_out = s_q.sync;

endmodule

// *** test/cbt_ctrl_bench.sv ***
`timescale 1ns/10ps
`include "cbt_params.svh"

module cbt_ctrl_bench;
    import cbt_pkg::*;
    localparam int CAL_NS = 50;
    localparam int CAL_N  = CAL_NS / `CBT_CLK_PERIOD_NS;

    logic             clock;
    logic             nrst;
    logic             strap;
    logic             pd;
    logic             sr;
    logic             mode_wr;
    logic             sel_wr;
    logic             point;
    logic             start;
    logic [2:0]       strength;
    logic [2:0]       sel;
    cbt_lines_type    ca_on;
    logic             ck_on;
    logic             cs_on;
    cbt_strength_type div;
    logic             busy;
    logic             recal;
    logic             forbid;
    logic [7:0]       term;
    int               n_errors;
    int               comparisons;

    assign term = {ca_on, ck_on, cs_on};

    cbt_ctrl #(.CAL_TIME_NS(CAL_NS)) dut (
        .clock(clock), .nrst(nrst),
        .termination_mode_reg_wr(mode_wr),
        .cmd_term_strength_field(strength),
        .termination_select_reg_wr(sel_wr),
        .cmd_line_term_disable(sel[2]),
        .clock_pair_term_enable(sel[1]),
        .chip_select_term_enable(sel[0]),
        .multirank_term_strap(strap), .power_down(pd),
        .self_refresh(sr), .pu_cal_point(point), .cal_start(start),
        .ca_term_on(ca_on), .ck_term_on(ck_on), .cs_term_on(cs_on),
        .term_divisor(div), .cal_busy(busy), .recal_needed(recal),
        .forbidden_setting(forbid)
    );

    cbt_ctrl_model ctl (
        .clock(clock), .cal_busy(busy), .mode_wr(mode_wr),
        .strength(strength), .sel_wr(sel_wr), .sel(sel),
        .point(point), .start(start)
    );

    // Expected {ca x6, ck, cs}; sel is {disable, ck enable, cs enable}
    function automatic logic [7:0] exp_term(logic [2:0] c, logic s,
                                            logic [2:0] b);
        if (c == 3'h0 || c == 3'h7) return 8'h00;
        if (!s) return {6'h00, b[1], b[0]};
        return {{6{~b[2]}}, 2'b11};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Inputs always move 2 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic wrap_up;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Hang guard, far beyond the fewer than 100 cycles needed
    initial begin
        #(25 * 4000);
        n_errors++;
        wrap_up();
    end

    // Test sequence
    initial begin
        int n;
        {nrst, strap, pd, sr} = 4'h0;
        n_errors = 0;
        comparisons = 0;
        step(6);
        nrst = 1'b1;
        chk(term, 8'h00);
        chk(8'(div), 8'h00);
        strap = 1'b1; // Terminating rank set up first
        ctl.cfg(0, 3'h2);
        for (int s = 1; s >= 0; s--) begin
            strap = s[0];
            step(3);
            for (int b = 0; b < 8; b++) begin
                ctl.cfg(1, b[2:0]);
                step(1);
                chk(term, exp_term(3'h2, s[0], b[2:0]));
            end
        end
        $display("test decode done");
        strap = 1'b1;
        ctl.cfg(1, 3'h0);
        step(3);
        for (int c = 0; c < 8; c++) begin
            ctl.cfg(0, c[2:0]);
            step(1);
            chk(8'(div), (c >= 1 && c <= 6) ? 8'(c) : 8'h00);
            chk(term, exp_term(c[2:0], 1'b1, 3'h0));
            chk(8'(forbid), 8'h00);
        end
        $display("test strength done");
        ctl.cfg(0, 3'h3);
        step(1);
        {pd, sr} = 2'h3;
        step(4);
        chk(term, 8'hff);
        chk(8'(div), 8'h03);
        {pd, sr} = 2'h0;
        $display("test power down done");
        ctl.set_point(1'b1);
        step(2);
        chk(8'(recal), 8'h01);
        ctl.calibrate(1'b1, n);
        chk(8'(n), 8'(CAL_N));
        chk(8'(recal), 8'h00);
        step(1);
        chk(8'(forbid), 8'h00);
        ctl.cfg(0, 3'h5); // Deliberate misuse at the high point
        step(1);
        chk(8'(forbid), 8'h01);
        chk(8'(div), 8'h05);
        chk(8'(recal), 8'h00);
        ctl.cfg(0, 3'h1);
        step(1);
        chk(8'(forbid), 8'h00);
        $display("test calibration done");
        nrst = 1'b0;
        step(2);
        nrst = 1'b1;
        chk(term, 8'h00);
        chk(8'(div), 8'h00);
        step(2);
        chk(8'(recal), 8'h01);
        $display("test reset done");
        wrap_up();
    end
endmodule

// *** test/cbt_ctrl_model.sv ***
`timescale 1ns/10ps

// Controller side: mode writes and calibration starts
module cbt_ctrl_model (
    input  wire logic  clock,
    input  wire logic  cal_busy,
    output logic       mode_wr,
    output logic [2:0] strength,
    output logic       sel_wr,
    output logic [2:0] sel,
    output logic       point,
    output logic       start
);
    // Quiet bus at time zero
    initial begin
        {mode_wr, sel_wr, point, start} = 4'h0;
        {strength, sel} = 6'h00;
    end

    // One write; the written field goes to junk once the strobe drops
    task automatic cfg(input logic which, input logic [2:0] v);
        while (cal_busy === 1'b1) begin
            @(posedge clock);
            #2;
        end
        if (which) begin
            sel = v;
            sel_wr = 1'b1;
        end else begin
            strength = v;
            mode_wr = 1'b1;
        end
        @(posedge clock);
        #2;
        {mode_wr, sel_wr} = 2'h0;
        sel = which ? ~v : sel;
        strength = which ? strength : ~v;
    endtask

    // Point level for the mode register
    task automatic set_point(input logic p);
        point = p;
    endtask

    // New point always runs a calibration; one stray start while busy
    task automatic calibrate(input logic p, output int n);
        while (cal_busy === 1'b1) begin
            @(posedge clock);
            #2;
        end
        point = p;
        start = 1'b1;
        @(posedge clock);
        #2;
        n = 0;
        while (cal_busy === 1'b1 && n < 50) begin
            n++;
            start = (n == 1); // Held one more edge; must be ignored
            @(posedge clock);
            #2;
        end
        start = 1'b0;
    endtask
endmodule
